// [tbc_defs.vh]
`ifndef TBC_DEFS_VH
`define TBC_DEFS_VH
`define TBC_OFF_STATUS0 8'h20
`define TBC_OFF_IER0 8'h24
`define TBC_OFF_IDR0 8'h28
`define TBC_OFF_IMR0 8'h2C
`define TBC_CHAN_STRIDE 8'h40
`define TBC_OFF_BCR 8'hC0
`define TBC_OFF_BMR 8'hC4
`define TBC_OFF_GSTAT 8'hD0
`define TBC_OFF_GMASK 8'hD4
`define TBC_OFF_FEAT 8'hF8
`define TBC_OFF_VERS 8'hFC
`define TBC_NCH 3
`define TBC_NFLAG 8
`define TBC_SYNC_BIT 0
`define TBC_SEL_PIN 2'h0
`define TBC_SEL_NONE 2'h1
`define TBC_SEL_A 2'h2
`define TBC_SEL_B 2'h3
`define TBC_L0_LSB 0
`define TBC_L1_LSB 2
`define TBC_L2_LSB 4
`define TBC_BMR_W 6
`define TBC_FEAT_BRIDGE_BIT 9
`define TBC_FEAT_UPDN_BIT 8
`define TBC_CTR_WIDTH 8'h10
`define TBC_VERSION 12'h123
`define TBC_VARIANT 4'h0
`define TBC_DIV_W 7
`define TBC_SEL_W 3
`define TBC_CLK_SLOW 3'h0
`define TBC_CLK_DIV2 3'h1
`define TBC_CLK_DIV8 3'h2
`define TBC_CLK_DIV32 3'h3
`define TBC_CLK_DIV128 3'h4
`define TBC_CLK_LINE0 3'h5
`define TBC_CLK_LINE1 3'h6
`define TBC_TAP_DIV2 0
`define TBC_TAP_DIV8 2
`define TBC_TAP_DIV32 4
`define TBC_TAP_DIV128 6
`define TBC_OSC_BIT 6
`define TBC_HTRANS_NONSEQ 2'h2
`define TBC_ZERO32 32'h00000000
`endif

// [tbc_top.v]
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tbc_defs.vh"
// How it works
// - enable port write of one sets that channel's mask bit; reset clears mask
// - disable port write of one clears mask bit; zero leaves it
// - eight mask bits: overflow, overrun, cmp a/b/c, capture a/b, ext trigger
// - block control bit 0 written one pulses sync trigger to all channels
// - line 2 select: pin2, none, chan0 out a, chan1 out a
// - line 1 select: pin1, none, chan0 out a, chan2 out a
// - line 0 select: pin0, none, chan1 out a, chan2 out a
// - capability bit 9 reports bus bridge kind
// - capability bit 8 reports up/down counting present
// - capability low byte gives counter width in bits
// - version register returns fixed 12-bit version number
// - variant field is reserved and steers nothing
// - each channel picks its own clock source independently
// - first internal clock source is the slow oscillator clock
// - register interface runs on its own bus interface clock
// - reading a channel status register clears the flags it reports
module tbc_top #(
    parameter BRIDGE_KIND = 1'b0,
    parameter UPDOWN_PRESENT = 1'b0
) (
    clk,
    rst_n,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    ext_clock_pin0,
    ext_clock_pin1,
    ext_clock_pin2,
    chan0_out_a,
    chan1_out_a,
    chan2_out_a,
    chan_events,
    slow_osc_clock,
    chan_clk_sel,
    chan_irq,
    sync_pulse,
    ext_clock_line0,
    ext_clock_line1,
    ext_clock_line2,
    chan_counter_clk,
    irq
);
    // clk is the dedicated bus interface clock
    input wire clk;
    input wire rst_n;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output reg hreadyout;
    output reg hresp;
    input wire ext_clock_pin0;
    input wire ext_clock_pin1;
    input wire ext_clock_pin2;
    input wire chan0_out_a;
    input wire chan1_out_a;
    input wire chan2_out_a;
    input wire [23:0] chan_events;
    input wire slow_osc_clock;
    input wire [8:0] chan_clk_sel;
    output reg [2:0] chan_irq;
    output reg sync_pulse;
    output reg ext_clock_line0;
    output reg ext_clock_line1;
    output reg ext_clock_line2;
    output reg [2:0] chan_counter_clk;
    output reg irq;

    function [0:0] tbc_route;
        input [1:0] sel;
        input pin;
        input a;
        input b;
        begin
            case (sel)
                `TBC_SEL_PIN: tbc_route = pin;
                `TBC_SEL_A: tbc_route = a;
                `TBC_SEL_B: tbc_route = b;
                default: tbc_route = 1'b0;
            endcase
        end
    endfunction

    // byte offset of a channel's register group; the integer product is cut
    // to the eight address bits that the block decodes
    function [7:0] tbc_chan_base;
        input integer ch;
        reg [31:0] full;
        begin
            full = ch * `TBC_CHAN_STRIDE;
            tbc_chan_base = full[7:0];
        end
    endfunction

    // data-phase decode shared by the registers that act on a write or on a status read
    function tbc_wr_hit;
        input pend;
        input [7:0] addr;
        input [7:0] off;
        begin
            tbc_wr_hit = pend && (addr == off);
        end
    endfunction

    // counter clock choice of one channel; all channels tap the same div_cnt divider and lines
    function tbc_clk_pick;
        input [2:0] sel;
        input osc;
        input [`TBC_DIV_W-1:0] div;
        input line0;
        input line1;
        input line2;
        begin
            case (sel)
                `TBC_CLK_SLOW: tbc_clk_pick = osc;
                `TBC_CLK_DIV2: tbc_clk_pick = div[`TBC_TAP_DIV2];
                `TBC_CLK_DIV8: tbc_clk_pick = div[`TBC_TAP_DIV8];
                `TBC_CLK_DIV32: tbc_clk_pick = div[`TBC_TAP_DIV32];
                `TBC_CLK_DIV128: tbc_clk_pick = div[`TBC_TAP_DIV128];
                `TBC_CLK_LINE0: tbc_clk_pick = line0;
                `TBC_CLK_LINE1: tbc_clk_pick = line1;
                default: tbc_clk_pick = line2;
            endcase
        end
    endfunction

    // two-stage synchronisers for the pins and neighbouring channel outputs
    reg [6:0] sync1;
    reg [6:0] sync2;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
        end else begin
            sync1 <= {slow_osc_clock, chan2_out_a, chan1_out_a, chan0_out_a,
                      ext_clock_pin2, ext_clock_pin1, ext_clock_pin0};
            sync2 <= sync1;
        end
    end

    // events come from the counter clock domains and are synchronised too;
    // a pulse shorter than one bus clock may be missed
    reg [23:0] ev1;
    reg [23:0] ev2;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev1 <= 24'h000000;
            ev2 <= 24'h000000;
        end else begin
            ev1 <= chan_events;
            ev2 <= ev1;
        end
    end

    // bus address phase capture
    reg wr_pend;
    reg rd_pend;
    reg [7:0] addr_q;
    wire take = hsel && hready && (htrans == `TBC_HTRANS_NONSEQ);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
        end
    end

    // the address is kept only for taken transfers; idle cycles leave it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 8'h00;
        end else if (take) begin
            addr_q <= haddr[7:0];
        end
    end

    reg [`TBC_BMR_W-1:0] block_mode_reg;
    reg [2:0] gmask;
    reg [2:0] gstat;
    reg [`TBC_NFLAG-1:0] irq_mask_reg [0:`TBC_NCH-1];
    reg [`TBC_NFLAG-1:0] channel_status_reg [0:`TBC_NCH-1];
    reg [2:0] rise;
    reg [`TBC_DIV_W-1:0] div_cnt;

    genvar g;
    generate
        for (g = 0; g < `TBC_NCH; g = g + 1) begin : chan
            wire [7:0] base = tbc_chan_base(g);
            wire ier_hit = tbc_wr_hit(wr_pend, addr_q, base + `TBC_OFF_IER0);
            wire idr_hit = tbc_wr_hit(wr_pend, addr_q, base + `TBC_OFF_IDR0);
            wire sr_rd = tbc_wr_hit(rd_pend, addr_q, base + `TBC_OFF_STATUS0);
            wire [7:0] ev = ev2[g*`TBC_NFLAG +: `TBC_NFLAG];
            wire [2:0] sel = chan_clk_sel[g*`TBC_SEL_W +: `TBC_SEL_W];

            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_mask_reg[g] <= 8'h00;
                end else if (ier_hit) begin
                    irq_mask_reg[g] <= irq_mask_reg[g] | hwdata[7:0];
                end else if (idr_hit) begin
                    irq_mask_reg[g] <= irq_mask_reg[g] & ~hwdata[7:0];
                end
            end

            // the read clears only what hrdata reported, so an event landing
            // between address and data phase survives; set beats clear
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    channel_status_reg[g] <= 8'h00;
                end else if (sr_rd) begin
                    channel_status_reg[g] <= (channel_status_reg[g] & ~hrdata[7:0]) | ev;
                end else begin
                    channel_status_reg[g] <= channel_status_reg[g] | ev;
                end
            end

            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    chan_irq[g] <= 1'b0;
                end else begin
                    chan_irq[g] <= |(channel_status_reg[g] & irq_mask_reg[g]);
                end
            end

            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    chan_counter_clk[g] <= 1'b0;
                end else begin
                    chan_counter_clk[g] <= tbc_clk_pick(sel, sync2[`TBC_OSC_BIT], div_cnt,
                                                        ext_clock_line0, ext_clock_line1,
                                                        ext_clock_line2);
                end
            end
        end
    endgenerate

    // divider on bus clock; bit k toggles at clk/2^(k+1)
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 7'h00;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    // block control, mode and summary interrupt
    wire bcr_hit = tbc_wr_hit(wr_pend, addr_q, `TBC_OFF_BCR);
    wire bmr_hit = tbc_wr_hit(wr_pend, addr_q, `TBC_OFF_BMR);
    wire gmask_hit = tbc_wr_hit(wr_pend, addr_q, `TBC_OFF_GMASK);
    wire gstat_hit = tbc_wr_hit(wr_pend, addr_q, `TBC_OFF_GSTAT);
    wire [2:0] gclr = gstat_hit ? hwdata[2:0] : 3'h0;

    // one-cycle trigger to every channel at once; zero writes do nothing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_pulse <= 1'b0;
        end else begin
            sync_pulse <= bcr_hit && hwdata[`TBC_SYNC_BIT];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            block_mode_reg <= {`TBC_BMR_W{1'b0}};
        end else if (bmr_hit) begin
            block_mode_reg <= hwdata[`TBC_BMR_W-1:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gmask <= 3'h0;
        end else if (gmask_hit) begin
            gmask <= hwdata[2:0];
        end
    end

    // rising channel irq sets summary bit; set beats clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise <= 3'h0;
            gstat <= 3'h0;
            irq <= 1'b0;
        end else begin
            rise <= chan_irq;
            gstat <= (gstat & ~gclr) | (chan_irq & ~rise);
            irq <= |(gstat & gmask);
        end
    end

    // external clock line routing; lines are sampled levels, not true clocks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_clock_line0 <= 1'b0;
        end else begin
            ext_clock_line0 <= tbc_route(block_mode_reg[`TBC_L0_LSB +: 2],
                                         sync2[0], sync2[4], sync2[5]);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_clock_line1 <= 1'b0;
        end else begin
            ext_clock_line1 <= tbc_route(block_mode_reg[`TBC_L1_LSB +: 2],
                                         sync2[1], sync2[3], sync2[5]);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_clock_line2 <= 1'b0;
        end else begin
            ext_clock_line2 <= tbc_route(block_mode_reg[`TBC_L2_LSB +: 2],
                                         sync2[2], sync2[3], sync2[4]);
        end
    end

    // read mux, answered in the data phase with no wait states
    reg [31:0] rd_val;
    always @* begin
        rd_val = `TBC_ZERO32;
        case (haddr[7:0])
            `TBC_OFF_IMR0: rd_val = {24'h000000, irq_mask_reg[0]};
            `TBC_OFF_IMR0 + tbc_chan_base(1): rd_val = {24'h000000, irq_mask_reg[1]};
            `TBC_OFF_IMR0 + tbc_chan_base(2): rd_val = {24'h000000, irq_mask_reg[2]};
            `TBC_OFF_STATUS0: rd_val = {24'h000000, channel_status_reg[0]};
            `TBC_OFF_STATUS0 + tbc_chan_base(1):
                rd_val = {24'h000000, channel_status_reg[1]};
            `TBC_OFF_STATUS0 + tbc_chan_base(2):
                rd_val = {24'h000000, channel_status_reg[2]};
            `TBC_OFF_BMR: rd_val = {26'h0000000, block_mode_reg};
            `TBC_OFF_GSTAT: rd_val = {29'h00000000, gstat};
            `TBC_OFF_GMASK: rd_val = {29'h00000000, gmask};
            `TBC_OFF_FEAT: rd_val = {22'h000000, BRIDGE_KIND[0],
                                     UPDOWN_PRESENT[0], `TBC_CTR_WIDTH};
            // variant is a constant and feeds nothing
            `TBC_OFF_VERS: rd_val = {12'h000, `TBC_VARIANT, 4'h0, `TBC_VERSION};
            default: rd_val = `TBC_ZERO32;
        endcase
    end

    // the slave never stretches a transfer and never signals an error
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data loaded as the address is taken, held until the next read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= `TBC_ZERO32;
        end else if (take && !hwrite) begin
            hrdata <= rd_val;
        end
    end
endmodule

// [tbc_props.sv]
`timescale 1ns/1ns
`include "tbc_defs.vh"
module tbc_props #(
    parameter BRIDGE_KIND = 1'b0,
    parameter UPDOWN_PRESENT = 1'b0
) (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire ext_clock_pin0,
    input wire chan0_out_a,
    input wire sync_pulse,
    input wire ext_clock_line0,
    input wire ext_clock_line1,
    input wire ext_clock_line2
);
    wire take = hsel && hready && htrans == `TBC_HTRANS_NONSEQ;
    wire rd_take = take && !hwrite;
    reg dbcr;
    reg dbmr;
    reg [5:0] block_mode;
    // shadow of the mode register, updated at the same edge as the design's
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbcr <= 1'b0;
            dbmr <= 1'b0;
            block_mode <= 6'h00;
        end else begin
            dbcr <= take && hwrite && haddr == 32'h000000C0;
            dbmr <= take && hwrite && haddr == 32'h000000C4;
            if (dbmr) begin
                block_mode <= hwdata[5:0];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sync_from_write_a: assert property (sync_pulse == $past(dbcr && hwdata[0]))
        else $error("sync pulse does not follow control write");
    version_read_a: assert property (rd_take && haddr == 32'h000000FC |=>
        hrdata == {12'h000, `TBC_VARIANT, 4'h0, `TBC_VERSION}) else $error("bad version");
    feature_read_a: assert property (rd_take && haddr == 32'h000000F8 |=>
        hrdata == {22'h0, BRIDGE_KIND, UPDOWN_PRESENT, `TBC_CTR_WIDTH}) else $error("bad features");
    rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("read data changed without a read");
    line0_pin_a: assert property ((block_mode[1:0] == 2'h0 && $stable(ext_clock_pin0))[*5] |->
        ext_clock_line0 == ext_clock_pin0) else $error("line 0 not routed from pin");
    line1_none_a: assert property ((block_mode[3:2] == `TBC_SEL_NONE)[*4] |-> !ext_clock_line1)
        else $error("line 1 active while unrouted");
    line2_out_a: assert property ((block_mode[5:4] == `TBC_SEL_A && $stable(chan0_out_a))[*5] |->
        ext_clock_line2 == chan0_out_a) else $error("line 2 not routed from channel 0");
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
endmodule
bind tbc_top tbc_props #(.BRIDGE_KIND(BRIDGE_KIND), .UPDOWN_PRESENT(UPDOWN_PRESENT)) u_props (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_clock_pin0(ext_clock_pin0), .chan0_out_a(chan0_out_a), .sync_pulse(sync_pulse),
    .ext_clock_line0(ext_clock_line0), .ext_clock_line1(ext_clock_line1),
    .ext_clock_line2(ext_clock_line2));

// [tbc_top_tb.sv]
`timescale 1ns/1ns
`include "tbc_defs.vh"
module tbc_top_tb;
    reg clk, rst_n, hsel, hwrite, osc;
    reg [1:0] htrans;
    reg [31:0] haddr, hwdata, rd;
    reg [5:0] pins;
    reg [23:0] ev;
    reg [8:0] csel;
    reg [2:0] cprev;
    wire [31:0] hrdata;
    wire hreadyout, hresp, sync_pulse, l0, l1, l2, irq;
    wire [2:0] chan_irq, cclk;
    integer error_cnt, checked, nsync, tick, i, s, p, k, b0, b1, b2;
    integer rise [0:2];
    tbc_top #(.BRIDGE_KIND(1'b1), .UPDOWN_PRESENT(1'b0)) DUT (.clk(clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_clock_pin0(pins[5]), .ext_clock_pin1(pins[4]),
        .ext_clock_pin2(pins[3]), .chan0_out_a(pins[2]), .chan1_out_a(pins[1]),
        .chan2_out_a(pins[0]), .chan_events(ev), .slow_osc_clock(osc), .chan_clk_sel(csel),
        .chan_irq(chan_irq), .sync_pulse(sync_pulse), .ext_clock_line0(l0),
        .ext_clock_line1(l1), .ext_clock_line2(l2), .chan_counter_clk(cclk), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // counts rising edges of each counter clock and sync pulses seen
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick % 16 == 15) osc <= ~osc;
        cprev <= cclk;
        nsync <= nsync + sync_pulse;
        for (k = 0; k < 3; k = k + 1) if (cclk[k] && !cprev[k]) rise[k] <= rise[k] + 1;
    end
    task complete_run;
        begin
            $display("checks %0d errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task xfer(input w, input [31:0] a, input [31:0] d);
        begin
            htrans <= `TBC_HTRANS_NONSEQ;
            haddr <= a;
            hwrite <= w;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    task rc(input [31:0] a, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            chk($sformatf("reg %h", a), e, rd);
        end
    endtask
    function ex(input [1:0] sl, input pn, input a, input b);
        ex = sl == 2'h0 ? pn : sl == 2'h1 ? 1'b0 : sl == 2'h2 ? a : b;
    endfunction
    initial begin
        #500000;
        error_cnt = error_cnt + 1;
        complete_run;
    end
    initial begin
        {rst_n, hwrite, osc, htrans, haddr, hwdata, pins, ev, csel, cprev} = 0;
        hsel = 1'b1;
        {error_cnt, checked, nsync, tick, rise[0], rise[1], rise[2]} = 0;
        cyc(12);
        rst_n <= 1'b1;
        cyc(1);
        for (i = 0; i < 3; i = i + 1) rc(`TBC_OFF_IMR0 + 32'h40 * i, 32'h0);
        rc(`TBC_OFF_BMR, 32'h0);
        rc(`TBC_OFF_FEAT, {22'h0, 2'b10, `TBC_CTR_WIDTH});
        xfer(1'b1, `TBC_OFF_VERS, 32'hFFFFFFFF);
        rc(`TBC_OFF_VERS, {12'h0, `TBC_VARIANT, 4'h0, `TBC_VERSION});
        xfer(1'b1, 32'hE0, 32'hFFFFFFFF);
        rc(32'hE0, 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            xfer(1'b1, `TBC_OFF_IER0 + 32'h40 * i, 32'h0F00 | (8'hA5 ^ i));
            xfer(1'b1, `TBC_OFF_IDR0 + 32'h40 * i, 32'h0);
        end
        for (i = 0; i < 3; i = i + 1) begin
            rc(`TBC_OFF_IMR0 + 32'h40 * i, 8'hA5 ^ i);
            xfer(1'b1, `TBC_OFF_IDR0 + 32'h40 * i, 32'h0F);
            rc(`TBC_OFF_IMR0 + 32'h40 * i, 8'hA0);
            xfer(1'b1, `TBC_OFF_IDR0 + 32'h40 * i, 32'hFFFFFFFF);
        end
        xfer(1'b1, `TBC_OFF_GMASK, 32'h1);
        ev <= 24'h000004;
        cyc(2);
        ev <= 24'h0;
        cyc(6);
        chk("chan_irq", 3'b000, chan_irq);
        xfer(1'b1, `TBC_OFF_IER0, 32'h4);
        cyc(4);
        chk("chan_irq", 3'b001, chan_irq);
        chk("irq", 1'b1, irq);
        rc(`TBC_OFF_STATUS0, 32'h4);
        cyc(4);
        chk("chan_irq", 3'b000, chan_irq);
        rc(`TBC_OFF_STATUS0, 32'h0);
        rc(`TBC_OFF_GSTAT, 32'h1);
        xfer(1'b1, `TBC_OFF_GMASK, 32'h0);
        cyc(3);
        chk("irq", 1'b0, irq);
        xfer(1'b1, `TBC_OFF_GSTAT, 32'h1);
        rc(`TBC_OFF_GSTAT, 32'h0);
        xfer(1'b1, `TBC_OFF_IER0 + 32'h80, 32'h80);
        ev <= 24'h800000;
        cyc(1);
        ev <= 24'h0;
        cyc(6);
        chk("chan_irq", 3'b100, chan_irq);
        rc(`TBC_OFF_STATUS0 + 32'h80, 32'h80);
        cyc(4);
        chk("chan_irq", 3'b000, chan_irq);
        xfer(1'b1, `TBC_OFF_BCR, 32'hFFFFFFFE);
        cyc(3);
        chk("sync count", 0, nsync);
        xfer(1'b1, `TBC_OFF_BCR, 32'h1);
        cyc(3);
        chk("sync count", 1, nsync);
        for (s = 0; s < 4; s = s + 1) for (p = 0; p < 2; p = p + 1) begin
            pins <= p ? 6'b010110 : 6'b101001;
            xfer(1'b1, `TBC_OFF_BMR, {3{s[1:0]}});
            cyc(6);
            rc(`TBC_OFF_BMR, {3{s[1:0]}});
            chk("lines", {ex(s, pins[5], pins[1], pins[0]), ex(s, pins[4], pins[2], pins[0]),
                ex(s, pins[3], pins[2], pins[1])}, {l0, l1, l2});
        end
        xfer(1'b1, `TBC_OFF_BMR, 32'h10);
        for (s = 1; s < 5; s = s + 1) begin
            csel <= {3'h7, s[2:0], 3'h0};
            cyc(8);
            {b0, b1, b2} = {rise[0], rise[1], rise[2]};
            cyc(256);
            chk("ch0 rises", 8, rise[0] - b0);
            chk("ch1 rises", 128 >> (2 * (s - 1)), rise[1] - b1);
            chk("ch2 rises", 0, rise[2] - b2);
        end
        complete_run;
    end
endmodule
